// *** logic/ealu_pkg.sv ***
// Shared constants, operation codes and carrier structs of the arithmetic and logic datapath.
package ealu_pkg;

  // Byte, I/O address and bit-select widths of the datapath.
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned IO_ADDR_W = 6;
  localparam int unsigned BIT_SEL_W = 3;

  // Status register bit positions; the two top bits belong to the core and stay zero here.
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;

  // Reset values, and the all-ones byte used to invert the clear mask.
  localparam logic [7:0] SREG_RST = 8'h00;
  localparam logic [7:0] PFLAG_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;

  // Address window of the bit-accessible I/O registers.
  localparam logic [5:0] IO_BIT_LO = 6'h00;
  localparam logic [5:0] IO_BIT_HI = 6'h1F;

  // Address of the write-one-to-clear peripheral flag register held in this block.
  localparam logic [5:0] PFLAG_ADDR = 6'h08;

  // Cycle counts of the operations at the 200 MHz core clock.
  localparam int unsigned BYTE_CYCLES = 1;
  localparam int unsigned WORD_CYCLES = 2;

  // Operation codes issued by the instruction decoder.
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_ADD_CARRY = 4'h1,
    OP_SUB = 4'h2,
    OP_DIFFERENCE_BORROW = 4'h3,
    OP_MINUS_CONSTANT = 4'h4,
    OP_MINUS_CONSTANT_BORROW = 4'h5,
    OP_WORD_PLUS_IMMEDIATE = 4'h6,
    OP_WORD_MINUS_IMMEDIATE = 4'h7,
    OP_CONJUNCTION_CONST = 4'h8,
    OP_DISJUNCTION_CONST = 4'h9,
    OP_SET_MASK_BITS = 4'hA,
    OP_CLEAR_MASK_BITS = 4'hB,
    OP_IO_BIT_SET = 4'hC,
    OP_IO_BIT_CLEAR = 4'hD,
    OP_SKIP_IO_BIT_HIGH = 4'hE,
    OP_SKIP_IO_BIT_LOW = 4'hF
  } ealu_op_e;

  // Request from the decoder and register file.
  typedef struct packed {
    logic valid;
    ealu_op_e op;
    logic [7:0] dst;
    logic [7:0] source_reg;
    logic [7:0] pair_hi;
    logic [5:0] io_addr;
    logic [2:0] bit_sel;
    logic [7:0] io_rdata;
  } ealu_req_s;

  // Result written back to the register file.
  typedef struct packed {
    logic valid;
    logic pair;
    logic [7:0] lo;
    logic [7:0] hi;
  } ealu_res_s;

  // Single-bit I/O access towards the peripherals.
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] data;
    logic [7:0] mask;
    logic skip;
    logic err;
  } ealu_io_s;

endpackage : ealu_pkg

// *** logic/ealu_byte_adder.sv ***
// Combinational 8-bit adder and subtractor with carry, half-carry and overflow outputs.
`timescale 1ns/100ps
module ealu_byte_adder (
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_cin,
  input wire logic i_sub,
  output logic [7:0] o_sum,
  output logic o_carry,
  output logic o_half,
  output logic o_ovf
);

  // Subtraction adds the inverted operand; the borrow enters as an inverted carry.
  wire logic [7:0] b_eff = i_sub ? ~i_b : i_b;
  wire logic c_eff = i_sub ? ~i_cin : i_cin;

  // Nine-bit sum keeps the carry out of bit 7; the nibble sum gives the half carry.
  wire logic [8:0] full_sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, c_eff};
  wire logic [4:0] nib_sum = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};

  assign o_sum = full_sum[7:0];
  // A subtract reports borrow, which is the inverse of the raw carry.
  assign o_carry = i_sub ? ~full_sum[8] : full_sum[8];
  assign o_half = i_sub ? ~nib_sum[4] : nib_sum[4];
  // Two's complement overflow: operands of like sign giving a result of the other sign.
  assign o_ovf = (i_a[7] == b_eff[7]) && (full_sum[7] != i_a[7]);

endmodule : ealu_byte_adder

// *** logic/ealu_io_bit.sv ***
// Combinational single-bit I/O access decoder for set, clear and test of low I/O registers.
`timescale 1ns/100ps
module ealu_io_bit (
  input wire logic [5:0] i_addr,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_rdata,
  input wire logic i_set,
  input wire logic i_clear,
  input wire logic i_test_high,
  input wire logic i_test_low,
  output logic o_in_range,
  output logic o_wr,
  output logic [7:0] o_data,
  output logic [7:0] o_mask,
  output logic o_skip
);

  // One-hot lane of the addressed bit.
  wire logic [7:0] lane = 8'h01 << i_bit_sel;

  // Only the low window is bit addressable; anything above is refused.
  assign o_in_range = (i_addr >= ealu_pkg::IO_BIT_LO) && (i_addr <= ealu_pkg::IO_BIT_HI);

  // The write touches the addressed lane only and carries zero elsewhere, so that
  // write-one-to-clear flags sharing the register are never hit by accident.
  assign o_wr = o_in_range && (i_set || i_clear);
  assign o_mask = o_wr ? lane : 8'h00;
  assign o_data = (o_in_range && i_set) ? lane : 8'h00;

  // Skip decisions read the addressed bit of the current register value.
  assign o_skip = o_in_range && ((i_test_high && |(i_rdata & lane)) || (i_test_low && ~|(i_rdata & lane)));

endmodule : ealu_io_bit

// *** logic/ealu_core.sv ***
// Top of the 8-bit arithmetic and logic datapath with status flags and I/O bit access.
//
// Behaviour
// - Register add, optional carry, one cycle, ZCNVH.
// - Word plus immediate on pair, two cycles, ZCNVS.
// - Register subtract, optional borrow, one cycle, ZCNVH.
// - Subtract constant from register, one cycle, ZCNVH.
// - Subtract constant and carry, update ZCNVH.
// - Word minus immediate on pair, two cycles, ZCNVS.
// - AND with constant, flags Z N V only.
// - OR with constant, flags Z N V only.
// - Set mask bits is OR, Z N V.
// - Clear mask bits ANDs inverted mask, Z N V.
// - Bit set, clear, skip only for 0x00-0x1F.
// - Bit writes touch addressed bit, zero elsewhere.
// - Peripheral flags clear on written one only.
`timescale 1ns/100ps
module ealu_core (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire ealu_pkg::ealu_req_s i_req,
  input wire logic [7:0] i_periph_evt,
  output ealu_pkg::ealu_res_s o_res,
  output ealu_pkg::ealu_io_s o_io,
  output logic [7:0] o_sreg,
  output logic [7:0] o_periph_flags,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer states and operation classes.
  ////////////////////////////////////////////////////////////////////////////////

  // The word operations need a second cycle for the high byte; all others finish in one.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WORD_HI = 2'b10
  } ealu_state_e;

  ealu_state_e state_r;
  ealu_state_e state_nxt;

  // A request is taken only while the sequencer is idle.
  wire logic take = i_req.valid && (state_r == ST_IDLE);
  wire ealu_pkg::ealu_op_e op = i_req.op;

  // Operation class decode.
  wire logic op_add = (op == ealu_pkg::OP_ADD) || (op == ealu_pkg::OP_ADD_CARRY);
  wire logic op_sub_byte = (op == ealu_pkg::OP_SUB) || (op == ealu_pkg::OP_DIFFERENCE_BORROW)
    || (op == ealu_pkg::OP_MINUS_CONSTANT) || (op == ealu_pkg::OP_MINUS_CONSTANT_BORROW);
  wire logic op_use_c = (op == ealu_pkg::OP_ADD_CARRY) || (op == ealu_pkg::OP_DIFFERENCE_BORROW)
    || (op == ealu_pkg::OP_MINUS_CONSTANT_BORROW);
  wire logic op_word = (op == ealu_pkg::OP_WORD_PLUS_IMMEDIATE) || (op == ealu_pkg::OP_WORD_MINUS_IMMEDIATE);
  wire logic op_word_sub = (op == ealu_pkg::OP_WORD_MINUS_IMMEDIATE);
  wire logic op_and = (op == ealu_pkg::OP_CONJUNCTION_CONST) || (op == ealu_pkg::OP_CLEAR_MASK_BITS);
  wire logic op_or = (op == ealu_pkg::OP_DISJUNCTION_CONST) || (op == ealu_pkg::OP_SET_MASK_BITS);
  wire logic op_logic = op_and || op_or;
  wire logic op_io_set = (op == ealu_pkg::OP_IO_BIT_SET);
  wire logic op_io_clr = (op == ealu_pkg::OP_IO_BIT_CLEAR);
  wire logic op_io_hi = (op == ealu_pkg::OP_SKIP_IO_BIT_HIGH);
  wire logic op_io_lo = (op == ealu_pkg::OP_SKIP_IO_BIT_LOW);
  wire logic op_io = op_io_set || op_io_clr || op_io_hi || op_io_lo;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  ////////////////////////////////////////////////////////////////////////////////

  // Status register; bits 7 and 6 are owned elsewhere in the core and read zero.
  logic [7:0] sreg_r;
  logic [7:0] sreg_nxt;
  // Word operation context held across the two cycles.
  logic [7:0] word_hi_r;
  logic [7:0] word_lo_r;
  logic word_sub_r;
  logic word_carry_r;
  // Write-one-to-clear peripheral flags.
  logic [7:0] pflag_r;
  logic [7:0] pflag_nxt;
  // Registered outputs.
  ealu_pkg::ealu_res_s res_r;
  ealu_pkg::ealu_res_s res_nxt;
  ealu_pkg::ealu_io_s io_r;
  ealu_pkg::ealu_io_s io_nxt;

  // Flag helpers used for the byte and word results.
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic unit, shared by the byte add and subtract operations and both halves of word operations.
  ////////////////////////////////////////////////////////////////////////////////

  // In the second word cycle the adder works on the high byte with a zero operand and
  // the carry or borrow left by the low byte; this gives the word's C and V directly.
  wire logic in_word_hi = (state_r == ST_WORD_HI);
  wire logic [7:0] add_a = in_word_hi ? word_hi_r : i_req.dst;
  wire logic [7:0] add_b = in_word_hi ? 8'h00 : i_req.source_reg;
  wire logic add_sub = in_word_hi ? word_sub_r : (op_sub_byte || op_word_sub);
  wire logic add_cin = in_word_hi ? word_carry_r : (op_use_c && sreg_r[ealu_pkg::FLG_C]);

  logic [7:0] add_sum;
  logic add_carry;
  logic add_half;
  logic add_ovf;

  ealu_byte_adder u_adder (
    .i_a(add_a),
    .i_b(add_b),
    .i_cin(add_cin),
    .i_sub(add_sub),
    .o_sum(add_sum),
    .o_carry(add_carry),
    .o_half(add_half),
    .o_ovf(add_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Logic unit.
  ////////////////////////////////////////////////////////////////////////////////

  // Clear-mask uses the inverted constant; conjunction uses it as given.
  wire logic [7:0] and_mask = (op == ealu_pkg::OP_CLEAR_MASK_BITS)
    ? (ealu_pkg::ALL_ONES - i_req.source_reg) : i_req.source_reg;
  wire logic [7:0] and_res = i_req.dst & and_mask;
  wire logic [7:0] or_res = i_req.dst | i_req.source_reg;
  wire logic [7:0] logic_res = op_and ? and_res : or_res;

  ////////////////////////////////////////////////////////////////////////////////
  // I/O bit unit.
  ////////////////////////////////////////////////////////////////////////////////

  logic io_in_range;
  logic io_wr;
  logic [7:0] io_data;
  logic [7:0] io_mask;
  logic io_skip;

  ealu_io_bit u_io_bit (
    .i_addr(i_req.io_addr),
    .i_bit_sel(i_req.bit_sel),
    .i_rdata(i_req.io_rdata),
    .i_set(take && op_io_set),
    .i_clear(take && op_io_clr),
    .i_test_high(take && op_io_hi),
    .i_test_low(take && op_io_lo),
    .o_in_range(io_in_range),
    .o_wr(io_wr),
    .o_data(io_data),
    .o_mask(io_mask),
    .o_skip(io_skip)
  );

  // Bit access to the local flag register: set lands on a flag, which writes a one and
  // therefore clears it; clear carries zero and leaves it alone.
  wire logic pflag_hit = io_wr && (i_req.io_addr == ealu_pkg::PFLAG_ADDR);
  wire logic [7:0] pflag_clr = pflag_hit ? (io_data & io_mask) : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state and result selection.
  ////////////////////////////////////////////////////////////////////////////////

  // The sequencer only leaves idle for the word operations.
  always_comb
  begin
    case (state_r)
      ST_IDLE:
      begin
        state_nxt = (take && op_word) ? ST_WORD_HI : ST_IDLE;
      end
      ST_WORD_HI:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Flags and result for each class; unlisted flags keep their value.
  always_comb
  begin
    sreg_nxt = sreg_r;
    res_nxt = '0;
    if (in_word_hi)
    begin
      // High byte of a word: Z spans both bytes, S is N xor V.
      res_nxt.valid = 1'b1;
      res_nxt.pair = 1'b1;
      res_nxt.lo = word_lo_r;
      res_nxt.hi = add_sum;
      sreg_nxt[ealu_pkg::FLG_Z] = is_zero(add_sum) && is_zero(word_lo_r);
      sreg_nxt[ealu_pkg::FLG_C] = add_carry;
      sreg_nxt[ealu_pkg::FLG_N] = add_sum[7];
      sreg_nxt[ealu_pkg::FLG_V] = add_ovf;
      sreg_nxt[ealu_pkg::FLG_S] = add_sum[7] ^ add_ovf;
    end
    else if (take && (op_add || op_sub_byte))
    begin
      // Byte add and subtract complete in this cycle with Z C N V H.
      res_nxt.valid = 1'b1;
      res_nxt.lo = add_sum;
      sreg_nxt[ealu_pkg::FLG_Z] = is_zero(add_sum);
      sreg_nxt[ealu_pkg::FLG_C] = add_carry;
      sreg_nxt[ealu_pkg::FLG_N] = add_sum[7];
      sreg_nxt[ealu_pkg::FLG_V] = add_ovf;
      sreg_nxt[ealu_pkg::FLG_H] = add_half;
    end
    else if (take && op_logic)
    begin
      // Logic results clear V and touch only Z N V.
      res_nxt.valid = 1'b1;
      res_nxt.lo = logic_res;
      sreg_nxt[ealu_pkg::FLG_Z] = is_zero(logic_res);
      sreg_nxt[ealu_pkg::FLG_N] = logic_res[7];
      sreg_nxt[ealu_pkg::FLG_V] = 1'b0;
    end
    else
    begin
      // First cycle of a word operation and I/O accesses leave the flags alone.
      sreg_nxt = sreg_r;
    end
  end

  // I/O access out; addresses above the window are refused with an error pulse.
  always_comb
  begin
    io_nxt = '0;
    io_nxt.wr = io_wr;
    io_nxt.addr = i_req.io_addr;
    io_nxt.data = io_data;
    io_nxt.mask = io_mask;
    io_nxt.skip = io_skip;
    io_nxt.err = take && op_io && !io_in_range;
  end

  // New events win over a clear in the same cycle, so no event is lost.
  assign pflag_nxt = (pflag_r & ~pflag_clr) | i_periph_evt;

  ////////////////////////////////////////////////////////////////////////////////
  // Clocked state.
  ////////////////////////////////////////////////////////////////////////////////

  // Sequencer, flags and registered outputs.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_r <= ST_IDLE;
      sreg_r <= ealu_pkg::SREG_RST;
      pflag_r <= ealu_pkg::PFLAG_RST;
      res_r <= '0;
      io_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      sreg_r <= sreg_nxt;
      pflag_r <= pflag_nxt;
      res_r <= res_nxt;
      io_r <= io_nxt;
    end
  end

  // Low byte of a word operation; the immediate adds to or subtracts from the low byte.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      word_hi_r <= 8'h00;
      word_lo_r <= 8'h00;
      word_sub_r <= 1'b0;
      word_carry_r <= 1'b0;
    end
    else if (take && op_word)
    begin
      word_hi_r <= i_req.pair_hi;
      word_lo_r <= add_sum;
      word_sub_r <= op_word_sub;
      word_carry_r <= add_carry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.
  ////////////////////////////////////////////////////////////////////////////////

  assign o_res = res_r;
  assign o_io = io_r;
  assign o_sreg = sreg_r;
  assign o_periph_flags = pflag_r;
  // Busy covers the high-byte cycle, during which a new request is not taken.
  assign o_busy = state_r[1];

endmodule : ealu_core

// *** tb/ealu_core_props.sv ***
// Concurrent checks of the arithmetic and logic datapath, seen from its top-level ports.
`timescale 1ns/100ps
module ealu_core_props (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire ealu_pkg::ealu_req_s i_req,
  input wire logic [7:0] i_periph_evt,
  input wire ealu_pkg::ealu_res_s o_res,
  input wire ealu_pkg::ealu_io_s o_io,
  input wire logic [7:0] o_sreg,
  input wire logic [7:0] o_periph_flags,
  input wire logic o_busy
);
  ////////////////////////////////////////////////////////////////////////////////
  // A request only counts when the datapath is free to take it.
  wire logic take = i_req.valid & ~o_busy;
  wire logic [3:0] op = i_req.op;
  wire logic [7:0] dst = i_req.dst;
  wire logic [7:0] src = i_req.source_reg;
  wire logic [2:0] bsel = i_req.bit_sel;
  wire logic io_hi = i_req.io_addr > ealu_pkg::IO_BIT_HI;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // Word operations: taken, one busy cycle, then the paired result.
  sequence s_take_word;
    take && (op == 4'h6 || op == 4'h7);
  endsequence
  sequence s_word_done;
    o_busy ##1 (o_res.valid && o_res.pair && !o_busy && o_sreg[5] == $past(o_sreg[5], 2));
  endsequence
  AST_BYTE_LAT: assert property ((take && (op < 4'h6 || (op > 4'h7 && op < 4'hC))) |=>
    (o_res.valid && !o_res.pair && !o_busy)) else $error("byte result not one cycle after take");
  AST_WORD_SEQ: assert property (s_take_word |=> s_word_done)
    else $error("word operation timing wrong");
  AST_BUSY_REFUSE: assert property (o_busy |=> (o_res.valid && o_res.pair && !o_busy
    && !o_io.wr && !o_io.skip && !o_io.err)) else $error("request during busy cycle was not refused");
  AST_LOGIC_FLAGS: assert property ((take && op > 4'h7 && op < 4'hC) |=>
    (!o_sreg[3] && (o_sreg & 8'h31) == ($past(o_sreg) & 8'h31))) else $error("logic op flags wrong");
  AST_CONJ_RESULT: assert property ((take && op == 4'h8) |=> o_res.lo == ($past(dst) & $past(src)))
    else $error("conjunction result wrong");
  AST_CLEAR_MASK: assert property ((take && op == 4'hB) |=> o_res.lo == ($past(dst) & ~$past(src)))
    else $error("clear mask result wrong");
  AST_SUB_ZERO: assert property ((take && op == 4'h2 && dst == src) |=>
    (o_sreg[1] && !o_sreg[0] && o_res.lo == 8'h00)) else $error("equal subtract flags wrong");
  AST_IO_RANGE: assert property ((take && op > 4'hB && io_hi) |=>
    (o_io.err && !o_io.wr && !o_io.skip)) else $error("out of range bit access not refused");
  AST_IO_SET: assert property ((take && op == 4'hC && !io_hi) |=>
    (o_io.wr && o_io.mask == (8'h01 << $past(bsel)) && o_io.data == o_io.mask)) else $error("bit set wrong");
  AST_W1C_SET: assert property ($past(i_nrst) |->
    ((o_periph_flags & $past(i_periph_evt)) == $past(i_periph_evt))) else $error("event did not set flag");
  // A written one clears its flag on the same edge that raises the write pulse.
  AST_W1C_KEEP: assert property (!o_io.wr |->
    ((o_periph_flags & $past(o_periph_flags)) == $past(o_periph_flags))) else $error("flag fell without write");
endmodule : ealu_core_props
bind ealu_core ealu_core_props i_props (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_req(i_req),
  .i_periph_evt(i_periph_evt), .o_res(o_res), .o_io(o_io), .o_sreg(o_sreg),
  .o_periph_flags(o_periph_flags), .o_busy(o_busy));

// *** tb/ealu_ioreg_model.sv ***
// Model of the core's bit-accessible I/O register space that answers bit tests.
`timescale 1ns/100ps
module ealu_ioreg_model (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire ealu_pkg::ealu_io_s i_io,
  input wire logic [5:0] i_addr,
  output logic [7:0] o_rdata
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] regs_r [0:31]; // Low I/O space only.
  logic tog_r; // Changes every cycle so nothing outside the space reads as stable.
  // Above the bit window nothing answers, so the read data is a moving pattern.
  assign o_rdata = i_addr[5] ? ({8{tog_r}} ^ 8'hA5) : regs_r[i_addr[4:0]];
  // A bit write touches only the masked bit; all other bits are written as zero and ignored.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tog_r <= 1'b0;
      for (int k = 0; k < 32; k++) regs_r[k] <= 8'h00;
    end
    else
    begin
      tog_r <= ~tog_r;
      if (i_io.wr && !i_io.addr[5])
        regs_r[i_io.addr[4:0]] <= (regs_r[i_io.addr[4:0]] & ~i_io.mask) | (i_io.data & i_io.mask);
    end
  end
endmodule : ealu_ioreg_model

// *** tb/tb_top.sv ***
// Self-checking testbench of the arithmetic and logic datapath.
`timescale 1ns/100ps
module tb_top;
  ////////////////////////////////////////////////////////////////////////////////
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  ealu_pkg::ealu_req_s req_r = '0; // Request as the bench drives it.
  ealu_pkg::ealu_req_s req_w; // Request with the modelled I/O read data merged in.
  logic [7:0] evt_r = 8'h00;
  ealu_pkg::ealu_res_s res;
  ealu_pkg::ealu_io_s io;
  logic [7:0] sreg;
  logic [7:0] pflags;
  logic [7:0] rd;
  logic busy;
  logic [7:0] sreg_m = ealu_pkg::SREG_RST; // Expected status after all issued operations.
  logic [24:0] res_q [$]; // Expected {pair, lo, hi, status}.
  ealu_pkg::ealu_io_s io_q [$];
  int num_errors = 0;
  int n_compared = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  always_comb
  begin
    req_w = req_r;
    req_w.io_rdata = rd;
  end
  ealu_core i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_req(req_w), .i_periph_evt(evt_r),
    .o_res(res), .o_io(io), .o_sreg(sreg), .o_periph_flags(pflags), .o_busy(busy));
  ealu_ioreg_model i_io (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_io(io), .i_addr(req_r.io_addr), .o_rdata(rd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string m);
    num_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("byte got %h expected %h", got, exp));
  endtask : chk8
  task automatic final_report;
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Issues one request and notes what it must produce. For bit tests b carries the register's known value.
  task automatic issue(input ealu_pkg::ealu_op_e op, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] hi, input logic [5:0] addr, input logic [2:0] bs);
    logic [8:0] r9;
    logic [4:0] h5;
    logic [16:0] w;
    logic [7:0] s;
    logic c;
    logic sb;
    ealu_pkg::ealu_io_s e;
    s = sreg_m;
    e = '0;
    sb = op inside {[ealu_pkg::OP_SUB:ealu_pkg::OP_MINUS_CONSTANT_BORROW], ealu_pkg::OP_WORD_MINUS_IMMEDIATE};
    c = (op inside {ealu_pkg::OP_ADD_CARRY, ealu_pkg::OP_DIFFERENCE_BORROW, ealu_pkg::OP_MINUS_CONSTANT_BORROW})
      ? sreg_m[0] : 1'b0;
    @(posedge i_ref_clk);
    req_r <= '{1'b1, op, a, b, hi, addr, bs, 8'h00};
    if (op <= ealu_pkg::OP_MINUS_CONSTANT_BORROW)
    begin
      r9 = sb ? {1'b0, a} - {1'b0, b} - c : {1'b0, a} + {1'b0, b} + c;
      h5 = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - c : {1'b0, a[3:0]} + {1'b0, b[3:0]} + c;
      s[0] = r9[8];
      s[1] = r9[7:0] == 8'h00;
      s[2] = r9[7];
      s[3] = (sb ? a[7] != b[7] : a[7] == b[7]) && r9[7] != a[7];
      s[5] = h5[4];
      res_q.push_back({1'b0, r9[7:0], 8'h00, s});
    end
    else if (op <= ealu_pkg::OP_WORD_MINUS_IMMEDIATE)
    begin
      w = sb ? {1'b0, hi, a} - {9'h000, b} : {1'b0, hi, a} + {9'h000, b};
      s[0] = w[16];
      s[1] = w[15:0] == 16'h0000;
      s[2] = w[15];
      s[3] = sb ? hi[7] & ~w[15] : ~hi[7] & w[15];
      s[4] = s[2] ^ s[3];
      res_q.push_back({1'b1, w[7:0], w[15:8], s});
      // The request is changed and held through the busy cycle, where it must be ignored.
      @(posedge i_ref_clk);
      req_r.op <= ealu_pkg::OP_ADD;
    end
    else if (op <= ealu_pkg::OP_CLEAR_MASK_BITS)
    begin
      r9[7:0] = (op == ealu_pkg::OP_CONJUNCTION_CONST) ? a & b : (op == ealu_pkg::OP_CLEAR_MASK_BITS)
        ? a & (8'hFF - b) : a | b;
      s[1] = r9[7:0] == 8'h00;
      s[2] = r9[7];
      s[3] = 1'b0;
      res_q.push_back({1'b0, r9[7:0], 8'h00, s});
    end
    else if (addr > ealu_pkg::IO_BIT_HI)
    begin
      e.err = 1'b1;
      io_q.push_back(e);
    end
    else
    begin
      e.wr = op inside {ealu_pkg::OP_IO_BIT_SET, ealu_pkg::OP_IO_BIT_CLEAR};
      e.addr = addr;
      e.mask = 8'h01 << bs;
      e.data = (op == ealu_pkg::OP_IO_BIT_SET) ? e.mask : 8'h00;
      e.skip = (op == ealu_pkg::OP_SKIP_IO_BIT_HIGH) ? b[bs] : (op == ealu_pkg::OP_SKIP_IO_BIT_LOW) && !b[bs];
      if (e.wr || e.skip) io_q.push_back(e);
    end
    sreg_m = s;
  endtask : issue
  task automatic idle(input int n);
    repeat (n) @(posedge i_ref_clk) req_r.valid <= 1'b0;
  endtask : idle
  ////////////////////////////////////////////////////////////////////////////////
  // Watches the outputs and matches each result against the oldest note.
  always @(negedge i_ref_clk)
  begin
    if (res.valid === 1'b1)
    begin
      n_compared++;
      if (res_q.size() == 0) fail("result without request");
      else if ({res.pair, res.lo, res.hi, sreg} !== res_q.pop_front()) fail("result or status mismatch");
    end
    if (io.wr === 1'b1 || io.skip === 1'b1 || io.err === 1'b1)
    begin
      n_compared++;
      if (io_q.size() == 0) fail("bit access without request");
      else if ({io.wr, io.skip, io.err} !== {io_q[0].wr, io_q[0].skip, io_q[0].err}) fail("bit access kind");
      else if (io.wr && {io.addr, io.data, io.mask} !== {io_q[0].addr, io_q[0].data, io_q[0].mask}) fail("bit write");
      if (io_q.size() != 0) void'(io_q.pop_front());
    end
  end
  // Cuts a hang short long after the expected run of under 150 cycles.
  initial
  begin
    #10000;
    fail("watchdog expired");
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] r;
    void'($urandom(32'he39c7ef1));
    repeat (12) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    // Boundary values of carry, overflow, half carry and word wrap.
    issue(ealu_pkg::OP_ADD, 8'hFF, 8'h01, 8'h00, 6'h00, 3'h0);
    issue(ealu_pkg::OP_ADD_CARRY, 8'h7F, 8'h00, 8'h00, 6'h00, 3'h0);
    issue(ealu_pkg::OP_SUB, 8'h3C, 8'h3C, 8'h00, 6'h00, 3'h0);
    issue(ealu_pkg::OP_MINUS_CONSTANT, 8'h00, 8'h01, 8'h00, 6'h00, 3'h0);
    issue(ealu_pkg::OP_MINUS_CONSTANT_BORROW, 8'h80, 8'h00, 8'h00, 6'h00, 3'h0);
    issue(ealu_pkg::OP_WORD_PLUS_IMMEDIATE, 8'hFF, 8'h01, 8'hFF, 6'h00, 3'h0);
    issue(ealu_pkg::OP_WORD_MINUS_IMMEDIATE, 8'h00, 8'h01, 8'h80, 6'h00, 3'h0);
    // Every operation code once, then random traffic; bit accesses land above the window.
    for (int k = 0; k < 76; k++)
    begin
      r = $urandom();
      issue(ealu_pkg::ealu_op_e'((k < 16) ? k[3:0] : r[3:0] % 4'hC), r[7:0], r[15:8], r[23:16],
            {1'b1, r[28:24]}, r[31:29]);
    end
    // Bit set, tests and clear inside the window, then one set above it.
    issue(ealu_pkg::OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 6'h11, 3'h5);
    idle(2);
    issue(ealu_pkg::OP_SKIP_IO_BIT_HIGH, 8'h00, 8'h20, 8'h00, 6'h11, 3'h5);
    issue(ealu_pkg::OP_SKIP_IO_BIT_LOW, 8'h00, 8'h20, 8'h00, 6'h11, 3'h5);
    issue(ealu_pkg::OP_SKIP_IO_BIT_LOW, 8'h00, 8'h20, 8'h00, 6'h11, 3'h4);
    issue(ealu_pkg::OP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00, 6'h11, 3'h5);
    idle(2);
    issue(ealu_pkg::OP_SKIP_IO_BIT_HIGH, 8'h00, 8'h00, 8'h00, 6'h11, 3'h5);
    issue(ealu_pkg::OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 6'h20, 3'h1);
    // Drop valid first, or the refused access would be taken a second time.
    idle(1);
    // Write-one-to-clear flags: set by events, cleared only by a written one.
    @(posedge i_ref_clk) evt_r <= 8'hFF;
    @(posedge i_ref_clk) evt_r <= 8'h00;
    idle(2);
    chk8(pflags, 8'hFF);
    issue(ealu_pkg::OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, ealu_pkg::PFLAG_ADDR, 3'h3);
    issue(ealu_pkg::OP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00, ealu_pkg::PFLAG_ADDR, 3'h2);
    idle(4);
    chk8(pflags, 8'hF7);
    // An event and a written one on the same flag in one cycle: the event wins.
    issue(ealu_pkg::OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, ealu_pkg::PFLAG_ADDR, 3'h0);
    evt_r <= 8'h01;
    idle(1);
    evt_r <= 8'h00;
    idle(2);
    chk8(pflags, 8'hF7);
    chk8(8'(res_q.size() + io_q.size()), 8'h00);
    final_report();
  end
endmodule : tb_top
